// File: shared/osm_pkg.sv
package osm_pkg;
	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] OSM_IDX_SYS1 = 8'h38;
	localparam logic [7:0] OSM_IDX_SYS2 = 8'h39;
	localparam logic [7:0] OSM_IDX_WAKE = 8'h3A;
	localparam logic [7:0] OSM_IDX_FLASH = 8'h3B;
	localparam logic [7:0] OSM_IDX_STAT = 8'h3C;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int OSM_B_STOP = 7;
	localparam int OSM_B_RELEASE_METHOD = 6;
	localparam int OSM_B_RETURN_MODE_SELECT = 5;
	localparam int OSM_B_OUTEN = 4;
	localparam int OSM_B_WUT = 2;
	localparam int OSM_B_HFEN = 7;
	localparam int OSM_B_LFEN = 6;
	localparam int OSM_B_MAIN_CLOCK_SELECT = 5;
	localparam int OSM_B_IDLE = 4;
	localparam int OSM_B_TGH = 2;
	// ------------------------------------------------------------
	// Reset values and flash wait counts (clock periods)
	// ------------------------------------------------------------
	localparam logic OSM_RST_HFEN = 1'b1;
	localparam logic OSM_RST_LFEN = 1'b0;
	localparam logic [17:0] OSM_FW_FAST = 18'h00400;
	localparam logic [17:0] OSM_FW_SLOW = 18'h00008;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OSM_RUN, OSM_CPU_HALT, OSM_GATED, OSM_STOPPED, OSM_WARMUP, OSM_FLASHWAIT
	} osm_state_t;
	typedef struct packed {
		logic stopBit;
		logic relmReg;
		logic relmEff;
		logic relmPend;
		logic return_mode_select;
		logic outen;
		logic [1:0] warmup_select;
		logic hfEn;
		logic lfEn;
		logic main_clock_select;
		logic idle;
		logic clock_gate_halt;
		logic [3:0] keyEn;
		logic flashPd;
		logic fpdAtStop;
	} osm_ctrl_t;
	typedef struct packed {
		osm_state_t st;
		osm_ctrl_t c;
		logic [17:0] cnt;
		logic pinS1;
		logic pinS2;
		logic pinPrev;
		logic [3:0] keyS1;
		logic [3:0] keyS2;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic hfOut;
		logic lfOut;
		logic cpuHalt;
		logic periphGate;
		logic allHalt;
		logic tgClear;
		logic rstReq;
		logic flashOut;
	} osm_regs_t;
endpackage : osm_pkg

// File: verilog/osm_clock_power.sv
// Functional notes
// - High and low frequency oscillator enable bits start or stop their oscillators.
// - Clock select writes 0 fast, 1 slow; reads return clock in use.
// - CPU-halt bit stops CPU and watchdog; peripherals keep running.
// - Clock-gate halt bit stops peripheral clocks except time base timer.
// - Reset when both oscillators off or selected clock's oscillator disabled.
// - CPU-halt bit clears itself on release.
// - Clock-gate halt bit clears itself on release.
// - Writing 1 to bit 7 of first control register enters STOP.
// - STOP stops oscillators, halts everything, holds all state.
// - Entering STOP clears timing generator prescaler and divider.
// - During STOP the program counter stays two past the start instruction.
// - Release method bit: 1 level-sensitive, 0 edge-sensitive.
// - Level release: STOP pin high or enabled key input low.
// - Level release: STOP start with condition present goes straight to warm-up.
// - Pin falling again during warm-up does not re-enter STOP.
// - Edge to level change waits for a rising pin edge.
// - Edge release: rising pin edge ends STOP; entry allowed with pin high.
// - Flash flag set at entry adds a CPU wait after warm-up.
// - Two-bit field selects one of four warm-up lengths per return clock.
// - Return mode bit: 0 fast clock, 1 slow single clock.
// - Release restarts oscillators, halts during warm-up, then resumes.
//
// Implementation choice: the APB slave port.
module osm_clock_power
	import osm_pkg::*;
#(
	parameter logic [3:0][17:0] WARM_FAST = {18'h04000, 18'h0C000, 18'h10000, 18'h30000},
	parameter logic [3:0][17:0] WARM_SLOW = {18'h00040, 18'h000C0, 18'h02000, 18'h06000}
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic stopPin,
	input wire logic [3:0] keyWakeN,
	input wire logic sleepWake,
	output logic hfOscOn,
	output logic lfOscOn,
	output logic mainClkSel,
	output logic cpuHalt,
	output logic periphGate,
	output logic allHalt,
	output logic flashWait,
	output logic tgClear,
	output logic sysResetReq,
	output logic portKeep
);
	osm_regs_t s;
	osm_regs_t n;
	logic pinRise;
	logic relCond;
	logic wrAcc;
	logic [7:0] idx;
	logic hit;

	// Pin conditions from synchronised copies only
	assign pinRise = s.pinS2 & ~s.pinPrev;
	assign relCond = s.pinS2 | (|(~s.keyS2 & s.c.keyEn));
	assign idx = paddr[9:2];
	assign hit = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0)
		&& (idx >= OSM_IDX_SYS1) && (idx <= OSM_IDX_STAT);
	assign wrAcc = psel & penable & s.pready & pwrite & ~s.pslverr;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic goWarm;
		logic [7:0] rd;
		goWarm = 1'b0;
		rd = 8'h00;
		n = s;
		n.tgClear = 1'b0;
		n.rstReq = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		// Two-flop synchronisers for the pins
		n.pinS1 = stopPin;
		n.pinS2 = s.pinS1;
		n.pinPrev = s.pinS2;
		n.keyS1 = keyWakeN;
		n.keyS2 = s.keyS1;
		// Deferred switch to level release
		if (s.c.relmPend && pinRise) begin
			n.c.relmEff = 1'b1;
			n.c.relmPend = 1'b0;
		end
		// APB read data captured in setup cycle
		unique case (idx)
			OSM_IDX_SYS1: rd = {s.c.stopBit, s.c.relmReg, s.c.return_mode_select, s.c.outen, s.c.warmup_select, 2'h0};
			OSM_IDX_SYS2: rd = {s.c.hfEn, s.c.lfEn, s.c.main_clock_select, s.c.idle, 1'b0, s.c.clock_gate_halt,
				2'h0};
			OSM_IDX_WAKE: rd = {4'h0, s.c.keyEn};
			OSM_IDX_FLASH: rd = {7'h00, s.c.flashPd};
			default: rd = {5'h00, s.st};
		endcase
		if (psel && !penable) begin
			n.pready = 1'b1;
			n.pslverr = ~hit;
			n.prdata = hit ? {24'h000000, rd} : 32'h00000000;
		end
		// Register writes
		if (wrAcc && idx == OSM_IDX_SYS2) begin
			// Illegal oscillator combination requests a reset
			if ((!pwdata[OSM_B_HFEN] && !pwdata[OSM_B_LFEN])
				|| (!pwdata[OSM_B_HFEN] && !pwdata[OSM_B_MAIN_CLOCK_SELECT])
				|| (!pwdata[OSM_B_LFEN] && pwdata[OSM_B_MAIN_CLOCK_SELECT])) begin
				n.rstReq = 1'b1;
			end
			n.c.hfEn = pwdata[OSM_B_HFEN];
			n.c.lfEn = pwdata[OSM_B_LFEN];
			n.c.main_clock_select = pwdata[OSM_B_MAIN_CLOCK_SELECT];
			if (s.st == OSM_RUN && pwdata[OSM_B_IDLE]) begin
				n.c.idle = 1'b1;
				n.st = OSM_CPU_HALT;
			end else if (s.st == OSM_RUN && pwdata[OSM_B_TGH]) begin
				n.c.clock_gate_halt = 1'b1;
				n.st = OSM_GATED;
			end
		end
		if (wrAcc && idx == OSM_IDX_WAKE) begin
			n.c.keyEn = pwdata[3:0];
		end
		if (wrAcc && idx == OSM_IDX_FLASH) begin
			n.c.flashPd = pwdata[0];
		end
		if (wrAcc && idx == OSM_IDX_SYS1) begin
			n.c.relmReg = pwdata[OSM_B_RELEASE_METHOD];
			// Level release only after a pin rising edge when coming from edge
			if (!pwdata[OSM_B_RELEASE_METHOD]) begin
				n.c.relmEff = 1'b0;
				n.c.relmPend = 1'b0;
			end else if (!s.c.relmEff) begin
				n.c.relmPend = 1'b1;
			end
			n.c.return_mode_select = pwdata[OSM_B_RETURN_MODE_SELECT];
			n.c.outen = pwdata[OSM_B_OUTEN];
			n.c.warmup_select = pwdata[OSM_B_WUT+1:OSM_B_WUT];
			if (pwdata[OSM_B_STOP] && s.st == OSM_RUN) begin
				n.c.stopBit = 1'b1;
				n.tgClear = 1'b1;
				n.c.fpdAtStop = s.c.flashPd;
				if (s.c.relmEff && relCond) begin
					goWarm = 1'b1;
				end else begin
					n.st = OSM_STOPPED;
				end
			end
		end
		// Mode sequencing
		unique case (s.st)
			OSM_RUN: begin
			end
			OSM_CPU_HALT: begin
				if (sleepWake) begin
					n.c.idle = 1'b0;
					n.st = OSM_RUN;
				end
			end
			OSM_GATED: begin
				if (sleepWake) begin
					n.c.clock_gate_halt = 1'b0;
					n.st = OSM_RUN;
				end
			end
			OSM_STOPPED: begin
				// Frozen until release; CPU keeps its advanced program counter
				if ((s.c.relmEff && relCond) || (!s.c.relmEff && pinRise)) begin
					goWarm = 1'b1;
				end
			end
			OSM_WARMUP: begin
				// Pin level is ignored here, so STOP is never re-entered
				if (s.cnt == 18'h00000) begin
					n.st = s.c.fpdAtStop ? OSM_FLASHWAIT : OSM_RUN;
					n.cnt = (s.c.return_mode_select ? OSM_FW_SLOW : OSM_FW_FAST) - 18'h00001;
					n.c.stopBit = s.c.fpdAtStop;
				end else begin
					n.cnt = s.cnt - 18'h00001;
				end
			end
			OSM_FLASHWAIT: begin
				if (s.cnt == 18'h00000) begin
					n.st = OSM_RUN;
					n.c.stopBit = 1'b0;
				end else begin
					n.cnt = s.cnt - 18'h00001;
				end
			end
			default: begin
				n.st = OSM_RUN;
			end
		endcase
		// Release: restart oscillators for the return mode, load warm-up
		if (goWarm) begin
			n.st = OSM_WARMUP;
			if (n.c.return_mode_select) begin
				n.c.lfEn = 1'b1;
				n.c.hfEn = 1'b0;
				n.c.main_clock_select = 1'b1;
				n.cnt = WARM_SLOW[n.c.warmup_select] - 18'h00001;
			end else begin
				n.c.hfEn = 1'b1;
				n.c.main_clock_select = 1'b0;
				n.cnt = WARM_FAST[n.c.warmup_select] - 18'h00001;
			end
		end
		// Registered outputs
		n.hfOut = n.c.hfEn && n.st != OSM_STOPPED;
		n.lfOut = n.c.lfEn && n.st != OSM_STOPPED;
		n.cpuHalt = n.st != OSM_RUN;
		n.periphGate = n.st == OSM_GATED;
		n.allHalt = n.st == OSM_STOPPED || n.st == OSM_WARMUP;
		n.flashOut = n.st == OSM_FLASHWAIT;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.st <= OSM_RUN;
			s.c.hfEn <= OSM_RST_HFEN;
			s.c.lfEn <= OSM_RST_LFEN;
			s.hfOut <= OSM_RST_HFEN;
			s.lfOut <= OSM_RST_LFEN;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from flops
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign hfOscOn = s.hfOut;
	assign lfOscOn = s.lfOut;
	assign mainClkSel = s.c.main_clock_select;
	assign cpuHalt = s.cpuHalt;
	assign periphGate = s.periphGate;
	assign allHalt = s.allHalt;
	assign flashWait = s.flashOut;
	assign tgClear = s.tgClear;
	assign sysResetReq = s.rstReq;
	assign portKeep = s.c.outen;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence stopWrite;
		wrAcc && idx == OSM_IDX_SYS1 && pwdata[OSM_B_STOP] && s.st == OSM_RUN;
	endsequence
	sequence warmDone;
		s.st == OSM_WARMUP && s.cnt == 18'h00000;
	endsequence

	stop_entry_a: assert property (stopWrite |=> (s.st == OSM_STOPPED || s.st == OSM_WARMUP)
		&& tgClear && s.c.stopBit) else $error("stop entry missed");
	osc_off_a: assert property (s.st == OSM_STOPPED |-> !hfOscOn && !lfOscOn)
		else $error("oscillator running in stop");
	idle_clear_a: assert property (s.st == OSM_CPU_HALT && sleepWake |=> s.st == OSM_RUN
		&& !s.c.idle) else $error("cpu halt bit not cleared");
	gate_clear_a: assert property (s.st == OSM_GATED && sleepWake |=> s.st == OSM_RUN
		&& !s.c.clock_gate_halt && !periphGate) else $error("gate halt bit not cleared");
	edge_release_a: assert property (s.st == OSM_STOPPED && !s.c.relmEff && pinRise
		|=> s.st == OSM_WARMUP && allHalt) else $error("edge release missed");
	warm_hold_a: assert property (s.st == OSM_WARMUP && s.cnt != 18'h00000
		|=> s.st == OSM_WARMUP) else $error("warm-up left early");
	bad_osc_a: assert property (wrAcc && idx == OSM_IDX_SYS2
		&& pwdata[OSM_B_HFEN:OSM_B_LFEN] == 2'h0 |=> sysResetReq)
		else $error("reset not requested");
	flash_wait_a: assert property (warmDone ##0 s.c.fpdAtStop |=> s.st == OSM_FLASHWAIT
		##1 cpuHalt) else $error("flash wait skipped");
	release_method_defer_a: assert property (s.c.relmPend && !pinRise |=> !s.c.relmEff)
		else $error("level release switched early");

	// ------------------------------------------------------------
	// Bus, reset request, sleep, stop and release sequencing checks
	// ------------------------------------------------------------
	sequence inStop;
		s.st == OSM_STOPPED;
	endsequence
	sequence enterWarm;
		s.st == OSM_WARMUP && allHalt;
	endsequence
	sequence firstWarm;
		s.st == OSM_STOPPED ##1 s.st == OSM_WARMUP;
	endsequence

	// Every setup cycle is answered one clock later
	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("setup not answered");

	// Ready is a single cycle pulse
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");

	// An error answer carries zero data
	err_data_a: assert property (pslverr |-> pready && prdata == 32'h00000000)
		else $error("error answer with data");

	// Reset request is a single cycle pulse
	rst_pulse_a: assert property (sysResetReq |=> !sysResetReq)
		else $error("reset request held");

	// Timing generator clear is one pulse, only with the stop bit set
	tg_pulse_a: assert property (tgClear |-> s.c.stopBit ##1 !tgClear)
		else $error("timing clear malformed");

	// CPU-halt write from run halts the CPU but not the peripherals
	idle_entry_a: assert property (wrAcc && idx == OSM_IDX_SYS2 && s.st == OSM_RUN
		&& pwdata[OSM_B_IDLE] |=> cpuHalt && !periphGate && s.c.idle)
		else $error("cpu halt entry missed");

	// Gate-halt write from run gates the peripheral clocks
	gate_entry_a: assert property (wrAcc && idx == OSM_IDX_SYS2 && s.st == OSM_RUN
		&& !pwdata[OSM_B_IDLE] && pwdata[OSM_B_TGH] |=> cpuHalt && periphGate && s.c.clock_gate_halt)
		else $error("gated sleep entry missed");

	// CPU-halt sleep lasts until the wake level arrives
	sleep_hold_a: assert property (s.st == OSM_CPU_HALT && !sleepWake
		|=> cpuHalt && s.c.idle)
		else $error("cpu halt left early");

	// Stop keeps the CPU and the whole chip halted
	stop_halt_a: assert property (inStop |-> cpuHalt && allHalt)
		else $error("stop not halting");

	// Edge mode leaves stop only on a pin rising edge
	edge_only_a: assert property (inStop ##0 (!s.c.relmEff && !pinRise)
		|=> s.st == OSM_STOPPED)
		else $error("edge mode released without edge");

	// Level mode leaves stop as soon as a release level is present
	level_release_a: assert property (inStop ##0 (s.c.relmEff && relCond)
		|=> enterWarm)
		else $error("level release missed");

	// Level mode stays stopped while no release level is present
	level_hold_a: assert property (inStop ##0 (s.c.relmEff && !relCond)
		|=> s.st == OSM_STOPPED)
		else $error("level mode released early");

	// Stop start with a release level present goes straight to warm-up
	level_skip_a: assert property (stopWrite ##0 (s.c.relmEff && relCond)
		|=> enterWarm)
		else $error("stop not skipped");

	// Warm-up never falls back into stop
	warm_nostop_a: assert property (s.st == OSM_WARMUP |=> s.st != OSM_STOPPED)
		else $error("stop re-entered");

	// Warm-up starts from the selected length for the return clock
	warm_len_a: assert property (firstWarm |-> s.cnt
		== (s.c.return_mode_select ? WARM_SLOW[s.c.warmup_select] : WARM_FAST[s.c.warmup_select]) - 18'h00001)
		else $error("warm-up length wrong");

	// Fast return restarts the fast oscillator and selects it
	ret_fast_a: assert property (inStop ##0 (!s.c.relmEff && pinRise && !s.c.return_mode_select)
		|=> !mainClkSel && hfOscOn)
		else $error("fast return wrong");

	// Slow return runs only the slow oscillator and selects it
	ret_slow_a: assert property (inStop ##0 (!s.c.relmEff && pinRise && s.c.return_mode_select)
		|=> mainClkSel && lfOscOn && !hfOscOn)
		else $error("slow return wrong");

	// Oscillators run during warm-up and the chip stays frozen
	warm_osc_a: assert property (s.st == OSM_WARMUP |-> allHalt
		&& (hfOscOn || lfOscOn))
		else $error("warm-up without oscillator");

	// Flash wait ends in run with the stop bit cleared
	flash_exit_a: assert property (s.st == OSM_FLASHWAIT && s.cnt == 18'h00000
		|=> s.st == OSM_RUN && !cpuHalt && !s.c.stopBit && !flashWait)
		else $error("flash wait exit wrong");
endmodule : osm_clock_power

// File: sim/osm_release_model.sv
module osm_release_model
	import osm_pkg::*;
(
	input wire logic clk,
	output logic stopPin,
	output logic [3:0] keyWakeN
);
	timeunit 1ns;
	timeprecision 100ps;
	// Release pin starts low, keys idle high through their pull-ups
	initial begin
		stopPin = 1'b0;
		keyWakeN = 4'hF;
	end
	// Pin is brought low before the first two level-mode starts; the third starts with it high
	task automatic setPin(input logic v);
		@(posedge clk);
		stopPin <= v;
	endtask : setPin
	// Keys held high before a level start; not relied on in edge mode
	task automatic setKeys(input logic [3:0] v);
		@(posedge clk);
		keyWakeN <= v;
	endtask : setKeys
endmodule : osm_release_model

// File: sim/oscillator_and_stop_mode_control_tb_top.sv
module oscillator_and_stop_mode_control_tb_top
	import osm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [3:0][17:0] WF = {18'h00004, 18'h00006, 18'h00008, 18'h0000C};
	localparam logic [3:0][17:0] WS = {18'h00003, 18'h00005, 18'h00007, 18'h00009};
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, sleepWake, stopPin, err;
	logic hfOscOn, lfOscOn, mainClkSel, cpuHalt, periphGate, allHalt, flashWait;
	logic tgClear, sysResetReq, portKeep;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0] keyWakeN;
	int errorCnt, nCompared, tgCnt, rstCnt, fwCnt, wuCnt, stCnt;
	osm_clock_power #(.WARM_FAST(WF), .WARM_SLOW(WS)) uut (.clk(clk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .stopPin(stopPin),
		.keyWakeN(keyWakeN), .sleepWake(sleepWake), .hfOscOn(hfOscOn), .lfOscOn(lfOscOn),
		.mainClkSel(mainClkSel), .cpuHalt(cpuHalt), .periphGate(periphGate),
		.allHalt(allHalt), .flashWait(flashWait), .tgClear(tgClear),
		.sysResetReq(sysResetReq), .portKeep(portKeep));
	osm_release_model rel (.clk(clk), .stopPin(stopPin), .keyWakeN(keyWakeN));
	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Counts pulses, warm-up, stopped and flash wait cycles
	always @(posedge clk) begin
		if (tgClear === 1'b1) tgCnt++;
		if (sysResetReq === 1'b1) rstCnt++;
		if (flashWait === 1'b1) fwCnt++;
		if (allHalt === 1'b1 && (hfOscOn | lfOscOn) === 1'b1) wuCnt++;
		if (allHalt === 1'b1 && (hfOscOn | lfOscOn) === 1'b0) stCnt++;
	end
	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			errorCnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic endSim;
		$display("Compared %0d, mismatches %0d", nCompared, errorCnt);
		if (errorCnt == 0 && nCompared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : endSim
	task automatic fail;
		errorCnt++;
		endSim();
	endtask : fail
	// Setup cycle, then access held until pready, then release
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {22'h000000, idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) fail();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	// Waits until the CPU runs again
	task automatic waitRun;
		int i;
		i = 0;
		while ((allHalt !== 1'b0 || cpuHalt !== 1'b0) && i < 3000) begin
			@(posedge clk);
			i++;
		end
		if (i >= 3000) fail();
	endtask : waitRun
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic scnReset;
		apb(1'b0, OSM_IDX_SYS2, 0);
		chk(rd, 32'h80);
		apb(1'b0, OSM_IDX_SYS1, 0);
		chk(rd, 32'h00);
		chk({hfOscOn, lfOscOn}, 2'b10);
		chk(portKeep, 1'b0);
		apb(1'b0, 8'h3F, 0);
		chk(err, 1'b1);
	endtask : scnReset
	task automatic scnOsc;
		logic [7:0] v[5] = '{8'hA0, 8'h00, 8'h40, 8'hC0, 8'h80};
		int n[5] = '{1, 1, 1, 0, 0};
		int r;
		apb(1'b1, OSM_IDX_SYS2, 32'hE0);
		apb(1'b0, OSM_IDX_SYS2, 0);
		chk(rd, 32'hE0);
		chk({mainClkSel, lfOscOn}, 2'b11);
		for (int i = 0; i < 5; i++) begin
			r = rstCnt;
			apb(1'b1, OSM_IDX_SYS2, {24'h000000, v[i]});
			repeat (2) @(posedge clk);
			chk(rstCnt - r, n[i]);
		end
		chk({hfOscOn, lfOscOn, mainClkSel}, 3'b100);
	endtask : scnOsc
	task automatic scnSleep;
		// Never both halt bits in one write; CPU halt before gating
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, OSM_IDX_SYS2, (i == 1) ? 32'h84 : 32'h90);
			chk({cpuHalt, periphGate}, {1'b1, i[0]});
			sleepWake <= 1'b1;
			repeat (3) @(posedge clk);
			sleepWake <= 1'b0;
			chk({cpuHalt, periphGate}, 2'b00);
			apb(1'b0, OSM_IDX_SYS2, 0);
			chk(rd, 32'h80);
		end
	endtask : scnSleep
	task automatic scnStop(input logic [31:0] s1, input logic [31:0] fl, input int wu, fw);
		int t, w, f;
		apb(1'b1, OSM_IDX_FLASH, fl);
		rel.setPin(1'b1);
		// Let the pin settle through the synchroniser before entry
		repeat (4) @(posedge clk);
		t = tgCnt;
		w = wuCnt;
		f = fwCnt;
		apb(1'b1, OSM_IDX_SYS1, s1);
		chk({allHalt, hfOscOn, lfOscOn}, 3'b100);
		chk(portKeep, s1[OSM_B_OUTEN]);
		repeat (20) @(posedge clk);
		chk(tgCnt - t, 1);
		chk(allHalt, 1'b1);
		rel.setPin(1'b0);
		repeat (3) @(posedge clk);
		rel.setPin(1'b1);
		waitRun();
		repeat (2) @(posedge clk);
		chk(wuCnt - w, wu);
		chk(fwCnt - f, fw);
		apb(1'b0, OSM_IDX_SYS1, 0);
		chk(rd[7], 1'b0);
	endtask : scnStop
	task automatic scnLevel;
		int w, s;
		apb(1'b1, OSM_IDX_WAKE, 1);
		apb(1'b1, OSM_IDX_SYS1, 32'h40);
		rel.setPin(1'b0);
		repeat (4) @(posedge clk);
		apb(1'b1, OSM_IDX_SYS1, 32'hC0);
		rel.setKeys(4'hE);
		repeat (10) @(posedge clk);
		chk(allHalt, 1'b1);
		rel.setKeys(4'hF);
		rel.setPin(1'b1);
		waitRun();
		rel.setPin(1'b0);
		repeat (4) @(posedge clk);
		apb(1'b1, OSM_IDX_SYS1, 32'hC0);
		chk(allHalt, 1'b1);
		rel.setKeys(4'hE);
		waitRun();
		rel.setKeys(4'hF);
		rel.setPin(1'b1);
		repeat (4) @(posedge clk);
		w = wuCnt;
		s = stCnt;
		apb(1'b1, OSM_IDX_SYS1, 32'hC0);
		rel.setPin(1'b0);
		waitRun();
		repeat (2) @(posedge clk);
		chk(stCnt - s, 0);
		chk(wuCnt - w, WF[0]);
	endtask : scnLevel
	// Main sequence
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		sleepWake = 1'b0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		scnReset();
		scnOsc();
		scnSleep();
		scnStop(32'h90, 0, WF[0], 0);
		scnStop(32'h9C, 1, WF[3], OSM_FW_FAST);
		scnStop(32'hB4, 0, WS[1], 0);
		chk({mainClkSel, hfOscOn, lfOscOn}, 3'b101);
		apb(1'b1, OSM_IDX_SYS2, 32'hC0);
		apb(1'b1, OSM_IDX_SYS2, 32'h80);
		scnLevel();
		endSim();
	end
	// Cuts a hang short
	initial begin
		#200000;
		fail();
	end
endmodule : oscillator_and_stop_mode_control_tb_top
